// file: iap_cfg.svh
// register offsets, field positions, key patterns and timing figures for the flash
// programming control block; included by the package and by the control module
`ifndef IAP_CFG_SVH
`define IAP_CFG_SVH

// register offsets on the plain register port
`define OFS_ADDR_LOW    4'h0
`define OFS_ADDR_HIGH   4'h1
`define OFS_DATA0_LOW   4'h2
`define OFS_DATA0_HIGH  4'h3
`define OFS_KEY1_LOW    4'h4
`define OFS_KEY1_HIGH   4'h5
`define OFS_KEY2_LOW    4'h6
`define OFS_KEY2_HIGH   4'h7
`define OFS_KEY3_LOW    4'h8
`define OFS_KEY3_HIGH   4'h9
`define OFS_MODE_CTRL   4'hA
`define OFS_CHIP_RESET  4'hB
`define OFS_BUF_CLEAR   4'hC

// mode and control field positions
`define BIT_EW_ENABLED  7
`define BIT_MODE_HI     6
`define BIT_MODE_LO     4
`define BIT_UNLOCK_TRIG 3
`define BIT_WRITE_START 2
`define BIT_READ_PERMIT 1
`define BIT_READ_START  0
`define BIT_BUF_CLEAR   0

// operation mode codes
`define MODE_CODE_WRITE  3'h0
`define MODE_CODE_ERASE  3'h1
`define MODE_CODE_READ   3'h3
`define MODE_CODE_UNLOCK 3'h6

// unlock key bytes, low registers then high registers
`define KEY1_LOW_VAL  8'h00
`define KEY2_LOW_VAL  8'h0D
`define KEY3_LOW_VAL  8'hC3
`define KEY1_HIGH_VAL 8'h04
`define KEY2_HIGH_VAL 8'h09
`define KEY3_HIGH_VAL 8'h40

// chip reset pattern
`define CHIP_RESET_KEY 8'h55

// reset values
`define RESET_BYTE 8'h00

// page geometry
`define PAGE_LAST_WORD 5'h1F

// timing
`define CLK_PERIOD_NS    4
`define ERASE_WRITE_NS   2200000
`define READ_INSTR_COUNT 3
`define INSTR_CYCLES     4
`define UNLOCK_CYCLES_DEF 1024

`endif

// file: iap_pkg.sv
// types shared by the flash programming control block and its testbench
// assumes iap_cfg.svh is on the include path
`include "iap_cfg.svh"

package iap_pkg;
   // operation modes held in the mode field
   typedef enum logic [2:0] {
      MODE_WRITE  = `MODE_CODE_WRITE,
      MODE_ERASE  = `MODE_CODE_ERASE,
      MODE_READ   = `MODE_CODE_READ,
      MODE_UNLOCK = `MODE_CODE_UNLOCK
   } op_mode_t;

   // command presented to the flash array
   typedef enum logic [1:0] {
      CMD_READ,
      CMD_ERASE,
      CMD_WRITE
   } flash_cmd_t;

   // sequencer states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ERASE,
      ST_WRITE,
      ST_READ
   } seq_state_t;
endpackage

// file: flash_iap_control_unlock.sv
// flash in-application programming control: registers, unlock sequence, write buffer,
// erase/write/read sequencing and cpu stall
// assumes a single-cycle register master on mclk_in and a flash array answering
// each request with a done pulse on the same clock
//
// What the document asks of this block and of its software
// RULE1: software cannot set the erase/write enabled flag
// RULE2: hardware sets flag on unlock; flag zero locks
// RULE3: mode codes: write, erase, read, unlock; rest reserved
// RULE4: erase and write only run while unlocked
// RULE5: trigger starts timer; timer expiry clears trigger
// RULE6: software writes six key bytes during timer
// RULE7: wrong key keeps locked; right key unlocks
// RULE8: software selects unlock mode, sets trigger, writes key
// RULE9: write start cleared by hardware when done
// RULE10: reads blocked unless read permit set
// RULE11: read start cleared by hardware when done
// RULE12: software never sets three start bits together
// RULE13: cpu stalled while an operation runs
// RULE14: writing 55h to reset key resets chip
// RULE15: buffer clear bit cleared when clear done
// RULE16: buffer clear upper bits read zero
// RULE17: software blank-checks erased page, erases again
// RULE18: software verifies write, clears buffer, rewrites
// RULE19: software clearing flag disables erase/write
// RULE20: 32-word buffer maps to page address bits
// RULE21: software erases first, subsidiary clock stable
// RULE22: high data write loads buffer, bumps address
// RULE23: erase or write lasts 2.2 ms
// RULE24: read takes three instruction cycles, data returned
// RULE25: unlock timer is a parameter; full key needed
// RULE26: durations in cycles, flash behind request/done
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`include "iap_cfg.svh"

module flash_iap_control_unlock #(
   parameter int CNT_W          = 20,                                  // timer width
   parameter int UNLOCK_CYCLES  = `UNLOCK_CYCLES_DEF,                  // unlock window
   parameter int ERASE_CYCLES   = `ERASE_WRITE_NS / `CLK_PERIOD_NS,    // page erase time
   parameter int WRITE_CYCLES   = `ERASE_WRITE_NS / `CLK_PERIOD_NS,    // page write time
   parameter int READ_CYCLES    = `READ_INSTR_COUNT * `INSTR_CYCLES    // word read time
) (
   // clock and reset
   input  wire logic                 mclk_in,
   input  wire logic                 rst_in,
   // register port
   input  wire logic [3:0]           reg_addr_in,
   input  wire logic [7:0]           reg_wdata_in,
   input  wire logic                 reg_wr_in,
   input  wire logic                 reg_rd_in,
   output logic      [7:0]           reg_rdata_out,
   // flash array handshake
   output logic                      flash_req_out,
   output iap_pkg::flash_cmd_t       flash_cmd_out,
   output logic      [12:0]          flash_addr_out,
   output logic      [15:0]          flash_wdata_out,
   input  wire logic [15:0]          flash_rdata_in,
   input  wire logic                 flash_done_in,
   // system effects
   output logic                      cpu_stall_out,
   output logic                      chip_reset_out
);
   import iap_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // state

   // every flip-flop of the block lives in this one record
   typedef struct packed {
      seq_state_t        state;       // sequencer state
      logic [7:0]        addr_lo;     // flash address bits 7..0
      logic [4:0]        addr_hi;     // flash address bits 12..8
      logic [7:0]        data_lo;     // first data register, low byte
      logic [7:0]        data_hi;     // first data register, high byte
      logic [5:0][7:0]   key;         // key1 lo, key1 hi, key2 lo, key2 hi, key3 lo, key3 hi
      logic              ew_flag;     // erase/write enabled flag
      logic [2:0]        mode;        // operation mode field
      logic              trig;        // unlock trigger
      logic              wstart;      // write start flag
      logic              rpermit;     // read permit
      logic              rstart;      // read start flag
      logic              clr;         // buffer clear flag
      logic [7:0]        rst_key;     // chip reset key register
      logic              chip_rst;    // chip reset pulse
      logic [31:0]       wvalid;      // buffer words loaded since last clear
      logic [31:0][15:0] wbuf;        // write buffer, one page
      logic [CNT_W-1:0]  unlock_cnt;  // unlock window countdown
      logic [CNT_W-1:0]  op_cnt;      // operation least-time countdown
      logic [4:0]        word_idx;    // buffer word being written
      logic              words_done;  // flash transfers of this operation finished
      logic              req;         // flash request level
      flash_cmd_t        cmd;         // flash command
      logic [12:0]       faddr;       // flash address presented
      logic [15:0]       fwdata;      // flash write data presented
      logic [7:0]        rdata;       // register read data
   } ctrl_t;

   ctrl_t c_reg;                      // registered state
   ctrl_t c_next;                     // next state

   logic       key_ok;                // all six key bytes hold the pattern
   logic       all_starts;            // write hits all three start bits at once
   logic [2:0] wr_mode;               // mode field carried by a control write
   logic       wr_trig;               // unlock trigger carried by a control write

   assign key_ok = (c_reg.key[0] == `KEY1_LOW_VAL)  && (c_reg.key[1] == `KEY1_HIGH_VAL) &&
                   (c_reg.key[2] == `KEY2_LOW_VAL)  && (c_reg.key[3] == `KEY2_HIGH_VAL) &&
                   (c_reg.key[4] == `KEY3_LOW_VAL)  && (c_reg.key[5] == `KEY3_HIGH_VAL);
   assign all_starts = reg_wdata_in[`BIT_WRITE_START] && reg_wdata_in[`BIT_READ_PERMIT] &&
                       reg_wdata_in[`BIT_READ_START];
   assign wr_mode = reg_wdata_in[`BIT_MODE_HI:`BIT_MODE_LO];
   assign wr_trig = reg_wdata_in[`BIT_UNLOCK_TRIG];

   ////////////////////////////////////////////////////////////////////////////////
   // next-state logic

   // register access, unlock timer and the operation sequencer
   always_comb begin
      c_next          = c_reg;
      c_next.rdata    = `RESET_BYTE;
      c_next.chip_rst = 1'b0;

      // read data stand only in the cycle after the strobe; unmapped reads give zero
      if (reg_rd_in) begin
         case (reg_addr_in)
            `OFS_ADDR_LOW:   c_next.rdata = c_reg.addr_lo;
            `OFS_ADDR_HIGH:  c_next.rdata = {3'h0, c_reg.addr_hi};
            `OFS_DATA0_LOW:  c_next.rdata = c_reg.data_lo;
            `OFS_DATA0_HIGH: c_next.rdata = c_reg.data_hi;
            `OFS_KEY1_LOW:   c_next.rdata = c_reg.key[0];
            `OFS_KEY1_HIGH:  c_next.rdata = c_reg.key[1];
            `OFS_KEY2_LOW:   c_next.rdata = c_reg.key[2];
            `OFS_KEY2_HIGH:  c_next.rdata = c_reg.key[3];
            `OFS_KEY3_LOW:   c_next.rdata = c_reg.key[4];
            `OFS_KEY3_HIGH:  c_next.rdata = c_reg.key[5];
            `OFS_MODE_CTRL:  c_next.rdata = {c_reg.ew_flag, c_reg.mode, c_reg.trig,
                                             c_reg.wstart, c_reg.rpermit, c_reg.rstart};
            `OFS_CHIP_RESET: c_next.rdata = c_reg.rst_key;
            `OFS_BUF_CLEAR:  c_next.rdata = {7'h00, c_reg.clr}; // RULE16
            default:         c_next.rdata = `RESET_BYTE;
         endcase
      end

      // unlock window: trigger falls when the count runs out, whatever the key
      if (c_reg.trig) begin
         if (c_reg.unlock_cnt == '0) begin
            c_next.trig = 1'b0; // RULE5
         end else begin
            c_next.unlock_cnt = c_reg.unlock_cnt - 1'b1;
         end
      end

      case (c_reg.state)
         ST_IDLE: begin
            // buffer clear takes one idle cycle; a new set in that cycle survives
            if (c_reg.clr) begin
               c_next.wbuf   = '0;
               c_next.wvalid = '0;
               c_next.clr    = 1'b0; // RULE15
            end
            // writes are taken only while idle: the cpu is halted otherwise
            if (reg_wr_in) begin
               case (reg_addr_in)
                  `OFS_ADDR_LOW:   c_next.addr_lo = reg_wdata_in;
                  `OFS_ADDR_HIGH:  c_next.addr_hi = reg_wdata_in[4:0];
                  `OFS_DATA0_LOW:  c_next.data_lo = reg_wdata_in;
                  `OFS_DATA0_HIGH: begin
                     c_next.data_hi = reg_wdata_in;
                     // loading needs the unlocked state and write mode
                     if (c_reg.ew_flag && c_reg.mode == MODE_WRITE) begin
                        c_next.wbuf[c_reg.addr_lo[4:0]]   = {reg_wdata_in, c_reg.data_lo}; // RULE22
                        c_next.wvalid[c_reg.addr_lo[4:0]] = 1'b1; // RULE20
                        // the address parks on the last word of the page
                        if (c_reg.addr_lo[4:0] != `PAGE_LAST_WORD) begin
                           c_next.addr_lo = c_reg.addr_lo + 8'h01; // RULE22
                        end
                     end
                  end
                  `OFS_KEY1_LOW:   c_next.key[0] = reg_wdata_in;
                  `OFS_KEY1_HIGH:  c_next.key[1] = reg_wdata_in;
                  `OFS_KEY2_LOW:   c_next.key[2] = reg_wdata_in;
                  `OFS_KEY2_HIGH:  c_next.key[3] = reg_wdata_in;
                  `OFS_KEY3_LOW:   c_next.key[4] = reg_wdata_in;
                  `OFS_KEY3_HIGH:  c_next.key[5] = reg_wdata_in;
                  `OFS_MODE_CTRL: begin
                     // a one on the enabled flag does nothing; a zero locks
                     if (!reg_wdata_in[`BIT_EW_ENABLED]) begin
                        c_next.ew_flag = 1'b0; // RULE1 RULE19
                     end
                     c_next.mode    = wr_mode;
                     c_next.rpermit = reg_wdata_in[`BIT_READ_PERMIT];
                     // trigger is honoured only together with unlock mode
                     if (wr_trig && wr_mode == MODE_UNLOCK) begin
                        c_next.trig       = 1'b1; // RULE5
                        c_next.unlock_cnt = CNT_W'(UNLOCK_CYCLES - 1); // RULE25
                     end
                     // a write that raises all three start bits starts nothing
                     if (!all_starts) begin // RULE12
                        if (reg_wdata_in[`BIT_WRITE_START] && c_next.ew_flag &&
                            (wr_mode == MODE_WRITE || wr_mode == MODE_ERASE)) begin // RULE3 RULE4
                           c_next.wstart     = 1'b1;
                           c_next.state      = (wr_mode == MODE_ERASE) ? ST_ERASE : ST_WRITE;
                           c_next.cmd        = (wr_mode == MODE_ERASE) ? CMD_ERASE : CMD_WRITE;
                           c_next.op_cnt     = (wr_mode == MODE_ERASE) ?
                                               CNT_W'(ERASE_CYCLES - 1) :
                                               CNT_W'(WRITE_CYCLES - 1); // RULE23 RULE26
                           c_next.word_idx   = 5'h00;
                           c_next.words_done = 1'b0;
                        end else if (reg_wdata_in[`BIT_READ_START] &&
                                     reg_wdata_in[`BIT_READ_PERMIT] &&
                                     wr_mode == MODE_READ) begin // RULE10 RULE3
                           c_next.rstart     = 1'b1;
                           c_next.state      = ST_READ;
                           c_next.cmd        = CMD_READ;
                           c_next.op_cnt     = CNT_W'(READ_CYCLES - 1); // RULE24
                           c_next.words_done = 1'b0;
                        end
                     end
                  end
                  `OFS_CHIP_RESET: begin
                     c_next.rst_key  = reg_wdata_in;
                     c_next.chip_rst = (reg_wdata_in == `CHIP_RESET_KEY); // RULE14
                  end
                  `OFS_BUF_CLEAR: begin
                     if (reg_wdata_in[`BIT_BUF_CLEAR]) begin
                        c_next.clr = 1'b1; // RULE15
                     end
                  end
                  default: begin
                     // unmapped write: ignored
                  end
               endcase
            end
         end
         ST_ERASE, ST_WRITE, ST_READ: begin
            // least duration runs alongside the flash transfers
            if (c_reg.op_cnt != '0) begin
               c_next.op_cnt = c_reg.op_cnt - 1'b1; // RULE26
            end
            if (!c_reg.words_done) begin
               if (c_reg.req) begin
                  // request held until the array answers
                  if (flash_done_in) begin
                     c_next.req = 1'b0;
                     if (c_reg.state == ST_READ) begin
                        {c_next.data_hi, c_next.data_lo} = flash_rdata_in; // RULE24
                     end
                     if (c_reg.state == ST_WRITE && c_reg.word_idx != `PAGE_LAST_WORD) begin
                        c_next.word_idx = c_reg.word_idx + 5'h01;
                     end else begin
                        c_next.words_done = 1'b1;
                     end
                  end
               end else if (c_reg.state != ST_WRITE || c_reg.wvalid[c_reg.word_idx]) begin
                  c_next.req    = 1'b1;
                  c_next.fwdata = c_reg.wbuf[c_reg.word_idx];
                  // writes land in the page named by the upper address bits
                  c_next.faddr  = (c_reg.state == ST_WRITE) ?
                                  {c_reg.addr_hi, c_reg.addr_lo[7:5], c_reg.word_idx} :
                                  {c_reg.addr_hi, c_reg.addr_lo}; // RULE20
               end else if (c_reg.word_idx != `PAGE_LAST_WORD) begin
                  // words never loaded are skipped
                  c_next.word_idx = c_reg.word_idx + 5'h01;
               end else begin
                  c_next.words_done = 1'b1;
               end
            end else if (c_reg.op_cnt == '0) begin
               // completion: start flags fall, a finished write empties the buffer
               c_next.wstart = 1'b0; // RULE9
               c_next.rstart = 1'b0; // RULE11
               if (c_reg.state == ST_WRITE) begin
                  c_next.wbuf   = '0;
                  c_next.wvalid = '0;
               end
               c_next.state = ST_IDLE;
            end
         end
         default: begin
            c_next.state = ST_IDLE;
         end
      endcase

      // correct key inside the window unlocks; hardware set wins over software clear
      if (c_reg.trig && key_ok) begin
         c_next.ew_flag = 1'b1; // RULE2 RULE7 RULE25
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // registers

   // one process holds all state
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         c_reg <= '0;
      end else begin
         c_reg <= c_next;
      end
   end

   // outputs from flip-flops, except the stall, decoded from the state
   assign reg_rdata_out   = c_reg.rdata;
   assign flash_req_out   = c_reg.req;
   assign flash_cmd_out   = c_reg.cmd;
   assign flash_addr_out  = c_reg.faddr;
   assign flash_wdata_out = c_reg.fwdata;
   assign cpu_stall_out   = (c_reg.state != ST_IDLE); // RULE13
   assign chip_reset_out  = c_reg.chip_rst;

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking chk_cb @(posedge mclk_in);
   endclocking
   default disable iff (rst_in);

   // flag rises only out of a matching key inside the window
   a_flag_hw_only: assert property ($rose(c_reg.ew_flag) |-> $past(c_reg.trig && key_ok)) // RULE1
      else $error("enabled flag rose without a valid unlock");

   // locked device never begins erase or write
   a_locked_no_op: assert property (
      (c_reg.state == ST_IDLE) && !c_reg.ew_flag && !(c_reg.trig && key_ok) |=>
      c_reg.state != ST_ERASE && c_reg.state != ST_WRITE) // RULE4
      else $error("erase or write began while locked");

   // trigger falls one cycle after the count reaches zero
   a_trig_expiry: assert property (
      c_reg.trig && c_reg.unlock_cnt == '0 && !reg_wr_in |=> !c_reg.trig) // RULE5
      else $error("unlock trigger outlived its window");

   // read never runs without the permit
   a_read_permit: assert property ($rose(c_reg.rstart) |-> c_reg.rpermit) // RULE10
      else $error("read started without permit");

   // cpu stalls in the cycle after the start, when the start flag rises
   a_stall_start: assert property (
      $rose(c_reg.wstart) || $rose(c_reg.rstart) |-> cpu_stall_out) // RULE13
      else $error("cpu not stalled during operation");

   // start flag falls only together with return to idle
   a_start_clear: assert property (
      $fell(c_reg.wstart) |-> c_reg.state == ST_IDLE && $past(c_reg.state) != ST_IDLE) // RULE9
      else $error("write start fell outside completion");

   // read start stays up for at least eight cycles after it rises
   a_read_length: assert property (
      $rose(c_reg.rstart) |-> !$fell(c_reg.rstart)[*8]) // RULE11
      else $error("read finished too early");

   // chip reset key produces one pulse
   a_chip_reset: assert property (
      reg_wr_in && reg_addr_in == `OFS_CHIP_RESET && reg_wdata_in == `CHIP_RESET_KEY &&
      c_reg.state == ST_IDLE |=> chip_reset_out ##1 !chip_reset_out) // RULE14
      else $error("chip reset pulse missing");

   // upper bits of the buffer clear register read zero
   a_clear_upper: assert property (
      reg_rd_in && reg_addr_in == `OFS_BUF_CLEAR |=> reg_rdata_out[7:1] == 7'h00) // RULE16
      else $error("buffer clear upper bits not zero");

   // address parks on the last page word
   a_page_stop: assert property (
      reg_wr_in && reg_addr_in == `OFS_DATA0_HIGH && c_reg.state == ST_IDLE &&
      c_reg.addr_lo[4:0] == `PAGE_LAST_WORD |=> c_reg.addr_lo[4:0] == `PAGE_LAST_WORD) // RULE22
      else $error("address crossed page boundary");

   // main scenarios
   c_unlock_ok:  cover property ($rose(c_reg.ew_flag));
   c_erase_done: cover property ($fell(c_reg.wstart) && $past(c_reg.state) == ST_ERASE);
   c_write_done: cover property ($fell(c_reg.wstart) && $past(c_reg.state) == ST_WRITE);
   c_read_done:  cover property ($fell(c_reg.rstart));

endmodule

// file: flash_iap_control_unlock_tb_top.sv
// testbench for the flash programming control block: register port tasks,
// flash array stand-in, directed tests; assumes iap_cfg.svh on the include path
`timescale 1ns/1ps
`include "iap_cfg.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin errors++; \
   $display("unexpected at %0t: got %0h expected %0h", $time, g, e); end end

module flash_iap_control_unlock_tb_top;
   import iap_pkg::*;
   logic             mclk_in = 1'b0;
   logic             rst_in = 1'b1;
   logic             reg_wr_in = 1'b0;
   logic             reg_rd_in = 1'b0;
   logic             flash_done_in = 1'b0;
   logic [3:0]       reg_addr_in = 4'h0;
   logic [7:0]       reg_wdata_in = 8'h00;
   logic [7:0]       reg_rdata_out;
   logic [7:0]       rv;                  // last value read
   logic [15:0]      flash_rdata_in = 16'h0000;
   logic [15:0]      flash_wdata_out;
   logic [12:0]      flash_addr_out;
   flash_cmd_t       flash_cmd_out;
   logic             flash_req_out;
   logic             cpu_stall_out;
   logic             chip_reset_out;
   logic [1:0]       dly = 2'h0;          // array answer delay
   int               errors = 0;
   int               num_checks = 0;
   int               nrst = 0;            // chip reset pulses seen
   int               cyc = 0;
   int               n;
   logic [12:0]      q_addr [$];          // log of finished array requests
   logic [15:0]      q_data [$];
   flash_cmd_t       q_cmd [$];

   always #2 mclk_in = ~mclk_in;

   // short counts so the whole run stays a few hundred cycles
   flash_iap_control_unlock #(.UNLOCK_CYCLES(16), .ERASE_CYCLES(40), .WRITE_CYCLES(40),
      .READ_CYCLES(12)) uut (.mclk_in(mclk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out), .flash_req_out(flash_req_out),
      .flash_cmd_out(flash_cmd_out), .flash_addr_out(flash_addr_out),
      .flash_wdata_out(flash_wdata_out), .flash_rdata_in(flash_rdata_in),
      .flash_done_in(flash_done_in), .cpu_stall_out(cpu_stall_out),
      .chip_reset_out(chip_reset_out));

   // array stand-in: answers each request on its third cycle, word derived from address
   always @(posedge mclk_in) begin
      flash_done_in <= 1'b0;
      if (flash_req_out && !flash_done_in) begin
         dly <= dly + 2'h1;
         if (dly == 2'h2) begin
            dly <= 2'h0;
            flash_done_in <= 1'b1;
            flash_rdata_in <= {3'h0, flash_addr_out} ^ 16'hA5C3;
            q_addr.push_back(flash_addr_out);
            q_data.push_back(flash_wdata_out);
            q_cmd.push_back(flash_cmd_out);
         end
      end
   end

   // pulse counter and hang guard
   always @(posedge mclk_in) begin
      cyc <= cyc + 1;
      if (chip_reset_out) nrst <= nrst + 1;
      if (cyc == 5000) begin
         errors++;
         tally_and_finish();
      end
   end

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      reg_wr_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge mclk_in);
      reg_wr_in <= 1'b0;
      #1;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a);
      @(posedge mclk_in);
      reg_rd_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge mclk_in);
      reg_rd_in <= 1'b0;
      #1 rv = reg_rdata_out;
   endtask

   // bounded wait for the stall to drop; n counts stalled cycles
   task automatic wait_idle();
      n = 0;
      while (cpu_stall_out && n < 400) begin
         @(posedge mclk_in);
         #1 n++;
      end
      `CHK(cpu_stall_out, 1'b0)
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      repeat (10) @(posedge mclk_in);
      rst_in <= 1'b0;
      for (int i = 4; i <= 12; i++) begin
         rd(i[3:0]);
         `CHK(rv, 8'h00)
      end
      wr(`OFS_MODE_CTRL, 8'h80);
      rd(`OFS_MODE_CTRL);
      `CHK(rv, 8'h00)
      wr(`OFS_MODE_CTRL, 8'h14);
      `CHK(cpu_stall_out, 1'b0)
      wr(`OFS_MODE_CTRL, 8'h37);
      `CHK(cpu_stall_out, 1'b0)
      $display("test locked done");
      // read without permit, then a real read of address 0325h
      wr(`OFS_ADDR_LOW, 8'h25);
      wr(`OFS_ADDR_HIGH, 8'h03);
      wr(`OFS_MODE_CTRL, 8'h31);
      `CHK(cpu_stall_out, 1'b0)
      wr(`OFS_MODE_CTRL, 8'h33);
      `CHK(cpu_stall_out, 1'b1)
      wait_idle();
      `CHK(q_cmd[0], CMD_READ)
      `CHK(q_addr[0], 13'h0325)
      rd(`OFS_MODE_CTRL);
      `CHK(rv, 8'h32)
      rd(`OFS_DATA0_LOW);
      `CHK(rv, 8'h25 ^ 8'hC3)
      rd(`OFS_DATA0_HIGH);
      `CHK(rv, 8'h03 ^ 8'hA5)
      $display("test read done");
      // wrong last key byte, then the right one
      wr(`OFS_KEY1_LOW, `KEY1_LOW_VAL);
      wr(`OFS_KEY2_LOW, `KEY2_LOW_VAL);
      wr(`OFS_KEY3_LOW, `KEY3_LOW_VAL);
      wr(`OFS_KEY1_HIGH, `KEY1_HIGH_VAL);
      wr(`OFS_KEY2_HIGH, `KEY2_HIGH_VAL);
      wr(`OFS_KEY3_HIGH, 8'h41);
      wr(`OFS_MODE_CTRL, 8'h68);
      rd(`OFS_MODE_CTRL);
      `CHK(rv, 8'h68)
      repeat (20) @(posedge mclk_in);
      rd(`OFS_MODE_CTRL);
      `CHK(rv, 8'h60)
      wr(`OFS_MODE_CTRL, 8'h60);
      wr(`OFS_MODE_CTRL, 8'h68);
      wr(`OFS_KEY3_HIGH, `KEY3_HIGH_VAL);
      rd(`OFS_MODE_CTRL);
      `CHK(rv, 8'hE8)
      repeat (20) @(posedge mclk_in);
      rd(`OFS_MODE_CTRL);
      `CHK(rv, 8'hE0)
      $display("test unlock done");
      // page erase at page 12h, then two words at the page end
      wr(`OFS_ADDR_HIGH, 8'h02);
      wr(`OFS_ADDR_LOW, 8'h5E);
      wr(`OFS_MODE_CTRL, 8'h94);
      wait_idle();
      `CHK(n >= 39, 1'b1)
      `CHK(q_cmd[1], CMD_ERASE)
      rd(`OFS_MODE_CTRL);
      `CHK(rv, 8'h90)
      // read back word 025Eh of the erased page before loading it; only command and address are checked
      wr(`OFS_MODE_CTRL, 8'hB3);
      wait_idle();
      `CHK(q_cmd[2], CMD_READ)
      `CHK(q_addr[2], 13'h025E)
      wr(`OFS_MODE_CTRL, 8'h80);
      wr(`OFS_DATA0_LOW, 8'h34);
      wr(`OFS_DATA0_HIGH, 8'h12);
      wr(`OFS_DATA0_LOW, 8'h78);
      wr(`OFS_DATA0_HIGH, 8'h56);
      rd(`OFS_ADDR_LOW);
      `CHK(rv, 8'h5F)
      wr(`OFS_MODE_CTRL, 8'h84);
      wait_idle();
      `CHK(q_addr.size(), 5)
      `CHK(q_addr[3], 13'h025E)
      `CHK(q_data[3], 16'h1234)
      `CHK(q_addr[4], 13'h025F)
      `CHK(q_data[4], 16'h5678)
      rd(`OFS_MODE_CTRL);
      `CHK(rv, 8'h80)
      // a cleared buffer writes nothing
      wr(`OFS_DATA0_HIGH, 8'h9A);
      wr(`OFS_BUF_CLEAR, 8'hFF);
      rd(`OFS_BUF_CLEAR);
      `CHK(rv, 8'h00)
      wr(`OFS_MODE_CTRL, 8'h84);
      wait_idle();
      `CHK(q_addr.size(), 5)
      $display("test erase write done");
      wr(`OFS_CHIP_RESET, 8'h54);
      `CHK(nrst, 0)
      wr(`OFS_CHIP_RESET, `CHIP_RESET_KEY);
      repeat (2) @(posedge mclk_in);
      `CHK(nrst, 1)
      wr(`OFS_MODE_CTRL, 8'h00);
      rd(`OFS_MODE_CTRL);
      `CHK(rv, 8'h00)
      wr(`OFS_MODE_CTRL, 8'h14);
      `CHK(cpu_stall_out, 1'b0)
      $display("test reset disable done");
      tally_and_finish();
   end
endmodule
